// ==== uwfi_pkg.sv ====
package uwfi_pkg;
	// oversampling: sixteen divided-clock ticks per serial bit
	localparam logic [3:0] OVS_LAST = 4'h_F;
	localparam logic [3:0] RX_MID = 4'h_7;
	localparam logic [3:0] IR_PULSE = 4'h_3;
	localparam logic [3:0] BAUD_HALF = 4'h_8;
	localparam logic [15:0] DIV_MIN = 16'h_0001;
	localparam logic [15:0] DIV_RESET = 16'h_0001;
	// stop length select and its length in ticks
	localparam logic [1:0] STOP_ONE = 2'h_0;
	localparam logic [1:0] STOP_ONE_HALF = 2'h_1;
	localparam logic [5:0] STOP1_TICKS = 6'h_10;
	localparam logic [5:0] STOP15_TICKS = 6'h_18;
	localparam logic [5:0] STOP2_TICKS = 6'h_20;
	// word length select: 0..3 means 5..8 data bits
	localparam logic [1:0] WORD_LEN_MAX = 2'h_3;
	localparam logic [2:0] WORD_LAST_BASE = 3'h_4;
	// interrupt identification codes, highest priority first
	localparam logic [3:0] IID_LINE = 4'h_6;
	localparam logic [3:0] IID_RXDATA = 4'h_4;
	localparam logic [3:0] IID_THRE = 4'h_2;
	localparam logic [3:0] IID_NONE = 4'h_1;
	localparam int FIFO_DEPTH = 16;
	localparam int DATA_W = 8;

	typedef enum logic [2:0] {
		SER_IDLE, SER_START, SER_DATA, SER_PAR, SER_STOP
	} uwfi_ser_t;
endpackage

// ==== uwfi_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwfi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// control
	input wire logic flush,
	input wire logic limitOne,
	// fill side
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	// drain side
	output logic rdValid,
	input wire logic rdReady,
	output logic [WIDTH-1:0] rdData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
	localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_ff, rdPtr_ff;
	logic [AW:0] count_ff;
	wire doWr = wrValid && wrReady;
	wire doRd = rdValid && rdReady;

	// character mode caps the store at one entry
	assign wrReady = limitOne ? (count_ff == '0) : (count_ff != FULL_CNT);
	assign rdValid = (count_ff != '0);
	assign rdData = mem[rdPtr_ff];

	always_ff @(posedge core_clk) begin
		if (doWr) begin
			mem[wrPtr_ff] <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else if (flush) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			if (doWr) begin
				wrPtr_ff <= wrPtr_ff + 1'b1;
			end
			if (doRd) begin
				rdPtr_ff <= rdPtr_ff + 1'b1;
			end
			if (doWr && !doRd) begin
				count_ff <= count_ff + CNT_ONE;
			end else if (doRd && !doWr) begin
				count_ff <= count_ff - CNT_ONE;
			end
		end
	end
endmodule
`default_nettype wire

// ==== uwfi_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwfi_top
	import uwfi_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// line configuration
	input wire logic [1:0] wordLen,
	input wire logic [1:0] stopSel,
	input wire logic parityEn,
	input wire logic parityEven,
	input wire logic fifoMode,
	input wire logic [15:0] divisor,
	input wire logic irEnable,
	// interrupt enables
	input wire logic ieRxData,
	input wire logic ieThre,
	input wire logic ieLineStat,
	// host port
	input wire logic txWrite,
	input wire logic [7:0] txData,
	input wire logic rxRead,
	input wire logic iirRead,
	input wire logic lineStatRead,
	output logic [7:0] rxData,
	output logic rxReady,
	output logic txFull,
	output logic txEmpty,
	output logic overrunErr,
	output logic parityErr,
	output logic frameErr,
	output logic [3:0] intId,
	output logic irq,
	// serial and infrared pins
	input wire logic serial_rx_in,
	output logic serial_tx_out,
	input wire logic irRxIn,
	output logic irTxOut,
	output logic baudOut
);
	function automatic logic [7:0] wordMask(input logic [1:0] len);
		return 8'h_FF >> (WORD_LEN_MAX - len);
	endfunction

	function automatic logic [2:0] lastBit(input logic [1:0] len);
		return WORD_LAST_BASE + {1'b0, len};
	endfunction

	function automatic logic [5:0] stopTicks(input logic [1:0] sel);
		return (sel == STOP_ONE) ? STOP1_TICKS :
			(sel == STOP_ONE_HALF) ? STOP15_TICKS : STOP2_TICKS;
	endfunction

	// baud generator
	logic [15:0] divCnt_ff;
	logic [3:0] subCnt_ff;
	logic baudOut_ff;
	wire divOk = (divisor >= DIV_MIN);
	wire divWrap = divOk && (divCnt_ff >= divisor);
	wire tick = divWrap;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_ff <= DIV_RESET;
			subCnt_ff <= '0;
			baudOut_ff <= 1'b0;
		end else begin
			divCnt_ff <= divWrap ? DIV_MIN : divCnt_ff + DIV_MIN;
			if (tick) begin
				subCnt_ff <= subCnt_ff + 4'h_1;
			end
			baudOut_ff <= (subCnt_ff >= BAUD_HALF);
		end
	end
	assign baudOut = baudOut_ff;

	// mode change flushes both stores so no stale word crosses modes
	logic fifoModeQ_ff;
	wire flush = (fifoModeQ_ff != fifoMode);

	// transmit store
	logic txValid, txPop, txWrReady;
	logic [7:0] txHead;
	uwfi_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) txStore (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(flush),
		.limitOne(!fifoMode),
		.wrValid(txWrite),
		.wrReady(txWrReady),
		.wrData(txData),
		.rdValid(txValid),
		.rdReady(txPop),
		.rdData(txHead)
	);
	assign txFull = !txWrReady;

	// transmitter
	uwfi_ser_t txState_ff;
	logic [3:0] txTick_ff;
	logic [5:0] txStop_ff;
	logic [2:0] txBit_ff;
	logic [7:0] txShift_ff;
	logic txPar_ff, txLine_ff;
	wire txBitEnd = tick && (txTick_ff == OVS_LAST);
	wire txStopEnd = tick && (txStop_ff == stopTicks(stopSel) - 6'h_01);
	// a queued char starts on the last stop tick, so no idle gap
	wire txLoad = (txState_ff == SER_IDLE) ||
		((txState_ff == SER_STOP) && txStopEnd);
	assign txPop = txLoad && txValid;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txState_ff <= SER_IDLE;
			txTick_ff <= '0;
			txStop_ff <= '0;
			txBit_ff <= '0;
			txShift_ff <= '0;
			txPar_ff <= 1'b0;
		end else begin
			if (tick) begin
				txTick_ff <= txTick_ff + 4'h_1;
			end
			case (txState_ff)
				SER_IDLE: txBit_ff <= '0;
				SER_START: if (txBitEnd) begin
					txBit_ff <= '0;
					txState_ff <= SER_DATA;
				end
				SER_DATA: if (txBitEnd) begin
					txShift_ff <= txShift_ff >> 1;
					txBit_ff <= txBit_ff + 3'h_1;
					if (txBit_ff == lastBit(wordLen)) begin
						txStop_ff <= '0;
						txState_ff <= parityEn ? SER_PAR : SER_STOP;
					end
				end
				SER_PAR: if (txBitEnd) begin
					txStop_ff <= '0;
					txState_ff <= SER_STOP;
				end
				SER_STOP: begin
					if (tick) begin
						txStop_ff <= txStop_ff + 6'h_01;
					end
					if (txStopEnd) begin
						txState_ff <= SER_IDLE;
					end
				end
				default: txState_ff <= SER_IDLE;
			endcase
			if (txPop) begin
				txShift_ff <= txHead & wordMask(wordLen);
				txPar_ff <= ^(txHead & wordMask(wordLen)) ^ !parityEven;
				txTick_ff <= '0;
				txState_ff <= SER_START;
			end
		end
	end

	wire nxt_txLine = (txState_ff == SER_START) ? 1'b0 :
		(txState_ff == SER_DATA) ? txShift_ff[0] :
		(txState_ff == SER_PAR) ? txPar_ff : 1'b1;
	// ir pulse marks the first three sixteenths of every zero bit
	wire nxt_irTx = irEnable && !nxt_txLine && (txTick_ff < IR_PULSE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			txLine_ff <= 1'b1;
			irTxOut <= 1'b0;
		end else begin
			txLine_ff <= nxt_txLine;
			irTxOut <= nxt_irTx;
		end
	end
	assign serial_tx_out = txLine_ff;
	assign txEmpty = !txValid && (txState_ff == SER_IDLE);

	// receive line: ir pulses stretched by a full bit of low level after they end
	logic [3:0] irHold_ff;
	logic irActive_ff, rxPrev_ff;
	wire rxLine = irEnable ? !(irActive_ff || irRxIn) : serial_rx_in;

	// receiver
	uwfi_ser_t rxState_ff;
	logic [3:0] rxTick_ff;
	logic [2:0] rxBit_ff;
	logic [7:0] rxShift_ff;
	logic rxParErr_ff;
	wire rxFall = rxPrev_ff && !rxLine;
	wire rxCentre = tick && (rxTick_ff == OVS_LAST);
	wire rxStartMid = tick && (rxTick_ff == RX_MID);
	wire rxDone = (rxState_ff == SER_STOP) && rxCentre;
	wire rxFrameBad = rxDone && !rxLine;
	wire rxBad = rxFrameBad || rxParErr_ff;
	wire rxPush = rxDone && !rxBad;
	wire [7:0] rxWord = rxShift_ff >> (WORD_LEN_MAX - wordLen);
	wire rxParCalc = ^(rxWord) ^ !parityEven;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irHold_ff <= '0;
			irActive_ff <= 1'b0;
			rxPrev_ff <= 1'b1;
		end else begin
			rxPrev_ff <= rxLine;
			if (irRxIn) begin
				irHold_ff <= '0;
				irActive_ff <= 1'b1;
			end else if (tick && irActive_ff) begin
				irHold_ff <= irHold_ff + 4'h_1;
				irActive_ff <= (irHold_ff != OVS_LAST);
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rxState_ff <= SER_IDLE;
			rxTick_ff <= '0;
			rxBit_ff <= '0;
			rxShift_ff <= '0;
			rxParErr_ff <= 1'b0;
		end else begin
			if (tick) begin
				rxTick_ff <= rxTick_ff + 4'h_1;
			end
			case (rxState_ff)
				SER_IDLE: if (rxFall && divOk) begin
					rxTick_ff <= '0;
					rxParErr_ff <= 1'b0;
					rxState_ff <= SER_START;
				end
				SER_START: if (rxStartMid) begin
					// a glitch shorter than half a bit is not a start
					rxTick_ff <= '0;
					rxBit_ff <= '0;
					rxState_ff <= rxLine ? SER_IDLE : SER_DATA;
				end
				SER_DATA: if (rxCentre) begin
					rxShift_ff <= {rxLine, rxShift_ff[7:1]};
					rxBit_ff <= rxBit_ff + 3'h_1;
					if (rxBit_ff == lastBit(wordLen)) begin
						rxState_ff <= parityEn ? SER_PAR : SER_STOP;
					end
				end
				SER_PAR: if (rxCentre) begin
					rxParErr_ff <= (rxLine != rxParCalc);
					rxState_ff <= SER_STOP;
				end
				// only the first stop bit is checked, so any length passes
				SER_STOP: if (rxCentre) begin
					rxState_ff <= SER_IDLE;
				end
				default: rxState_ff <= SER_IDLE;
			endcase
		end
	end

	// receive store
	logic rxWrReady;
	uwfi_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) rxStore (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.flush(flush),
		.limitOne(!fifoMode),
		.wrValid(rxPush),
		.wrReady(rxWrReady),
		.wrData(rxWord),
		.rdValid(rxReady),
		.rdReady(rxRead),
		.rdData(rxData)
	);

	// sticky status: a new event in the clearing cycle wins
	logic threPend_ff, txValidQ_ff;
	wire setOverrun = rxPush && !rxWrReady;
	wire setThre = txValidQ_ff && !txValid;
	wire clrThre = txWrite || (iirRead && intId == IID_THRE);
	wire lineInt = ieLineStat && (overrunErr || parityErr || frameErr);
	wire rxInt = ieRxData && rxReady;
	wire threInt = ieThre && threPend_ff;
	wire [3:0] nxt_intId = lineInt ? IID_LINE : rxInt ? IID_RXDATA :
		threInt ? IID_THRE : IID_NONE;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fifoModeQ_ff <= 1'b0;
			txValidQ_ff <= 1'b0;
			threPend_ff <= 1'b0;
			overrunErr <= 1'b0;
			parityErr <= 1'b0;
			frameErr <= 1'b0;
			intId <= IID_NONE;
			irq <= 1'b0;
		end else begin
			fifoModeQ_ff <= fifoMode;
			txValidQ_ff <= txValid;
			threPend_ff <= setThre || (threPend_ff && !clrThre);
			overrunErr <= setOverrun || (overrunErr && !lineStatRead);
			parityErr <= (rxDone && rxParErr_ff) ||
				(parityErr && !lineStatRead);
			frameErr <= rxFrameBad || (frameErr && !lineStatRead);
			intId <= nxt_intId;
			irq <= lineInt || rxInt || threInt;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	tick_spacing_a: assert property (
		tick && divisor > DIV_MIN && $stable(divisor) |=> !tick
	) else $error("divided tick repeated too soon");

	sub_wrap_a: assert property (
		tick && subCnt_ff == OVS_LAST |=> subCnt_ff == '0
	) else $error("sixteenth divider did not wrap");

	tx_start_a: assert property (
		txState_ff == SER_START && $past(txState_ff) == SER_START
		|-> !serial_tx_out
	) else $error("start bit not low");

	tx_stop_a: assert property (
		txState_ff == SER_STOP && $past(txState_ff) == SER_STOP
		|-> serial_tx_out
	) else $error("stop bit not high");

	frame_flag_a: assert property (
		rxFrameBad |=> frameErr
	) else $error("framing error not flagged");

	push_clean_a: assert property (
		rxPush |-> !rxParErr_ff && rxLine
	) else $error("bad character stored");

	push_seen_a: assert property (
		rxPush && rxWrReady && !flush |=> rxReady
	) else $error("good character not stored");

	irq_source_a: assert property (
		threInt && !lineInt |=> irq
	) else $error("empty interrupt missing");

	iid_none_a: assert property (
		!irq |-> intId == IID_NONE
	) else $error("idle code wrong");

	char_cap_a: assert property (
		!fifoMode && !flush && rxReady |-> !rxWrReady
	) else $error("character mode holds more than one");

	ir_pulse_a: assert property (
		irTxOut |-> irEnable && !serial_tx_out
	) else $error("ir pulse outside zero bit");
endmodule
`default_nettype wire

// ==== uwfi_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module uwfi_peer (
	// clock
	input wire logic core_clk,
	// line settings shared with the block
	input wire logic [1:0] wordLen,
	input wire logic parityEn,
	input wire logic [15:0] divisor,
	// serial lines
	input wire logic txLine,
	output logic rxLine,
	output logic irLine
);
	logic [7:0] gotD[$];
	logic gotP[$];
	int gotT[$];
	int cyc = 0;

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
	end

	initial begin
		rxLine = 1'b1;
		irLine = 1'b0;
	end

	// a zero bit also gives a three-tick infrared pulse
	task automatic drive_bit(input logic b);
		rxLine = b;
		irLine = !b;
		repeat (3 * divisor) @(negedge core_clk);
		irLine = 1'b0;
		repeat (13 * divisor) @(negedge core_clk);
	endtask

	// stop is held three bit times so every stop setting sees it
	task automatic send(input logic [7:0] d, input logic ev,
		input logic badPar, input logic badStop);
		logic p;
		p = !ev ^ badPar;
		@(negedge core_clk);
		drive_bit(1'b0);
		for (int i = 0; i < wordLen + 5; i++) begin
			drive_bit(d[i]);
			p ^= d[i];
		end
		if (parityEn) begin
			drive_bit(p);
		end
		drive_bit(!badStop);
		drive_bit(1'b1);
		drive_bit(1'b1);
	endtask

	// watcher of the block's output line, sampling at bit centres
	initial forever begin
		logic [7:0] d;
		logic p;
		int t;
		@(negedge txLine);
		t = cyc;
		repeat (8 * divisor) @(posedge core_clk);
		if (txLine === 1'b0) begin
			d = 8'h_00;
			p = 1'b0;
			for (int i = 0; i < wordLen + 5; i++) begin
				repeat (16 * divisor) @(posedge core_clk);
				d[i] = txLine;
			end
			if (parityEn) begin
				repeat (16 * divisor) @(posedge core_clk);
				p = txLine;
			end
			repeat (16 * divisor) @(posedge core_clk);
			gotD.push_back(d);
			gotP.push_back(p);
			gotT.push_back(t);
		end
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
	import uwfi_pkg::*;
	typedef struct packed {
		logic [1:0] wl;
		logic pe;
		logic ev;
		logic [7:0] d;
	} uwfi_row_t;
	uwfi_row_t rows[4] = '{'{2'h_0, 1'h_1, 1'h_1, 8'h_15},
		'{2'h_1, 1'h_1, 1'h_0, 8'h_EA}, '{2'h_2, 1'h_0, 1'h_0, 8'h_5A},
		'{2'h_3, 1'h_1, 1'h_0, 8'h_A5}};
	logic [5:0] stopLen[3] = '{STOP1_TICKS, STOP15_TICKS, STOP2_TICKS};
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] wordLen = 2'h_3;
	logic [1:0] stopSel = STOP_ONE;
	logic parityEn = 1'b0, parityEven = 1'b0, fifoMode = 1'b0;
	logic irEnable = 1'b0, ieRxData = 1'b0, ieThre = 1'b0;
	logic ieLineStat = 1'b0, txWrite = 1'b0, rxRead = 1'b0;
	logic iirRead = 1'b0, lineStatRead = 1'b0;
	logic [15:0] divisor = DIV_RESET;
	logic [7:0] txData = 8'h_00;
	logic [7:0] rxData;
	logic rxReady, txFull, txEmpty, overrunErr, parityErr, frameErr, irq;
	logic [3:0] intId;
	logic serial_rx_in, serial_tx_out, irRxIn, irTxOut, baudOut;
	int fail_count = 0;
	int num_checks = 0;

	uwfi_top dut (.core_clk, .rst_n, .wordLen, .stopSel, .parityEn,
		.parityEven, .fifoMode, .divisor, .irEnable, .ieRxData, .ieThre,
		.ieLineStat, .txWrite, .txData, .rxRead, .iirRead, .lineStatRead,
		.rxData, .rxReady, .txFull, .txEmpty, .overrunErr, .parityErr,
		.frameErr, .intId, .irq, .serial_rx_in, .serial_tx_out, .irRxIn,
		.irTxOut, .baudOut);
	uwfi_peer peer (.core_clk, .wordLen, .parityEn, .divisor,
		.txLine(serial_tx_out), .rxLine(serial_rx_in), .irLine(irRxIn));

	initial forever #2 core_clk = ~core_clk;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic bail(input int k);
		if (k >= 20000) begin
			fail_count++;
			complete_run();
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return rxReady;
			1: return irq;
			default: return txEmpty;
		endcase
	endfunction

	task automatic wait_hi(input int sel);
		int k;
		for (k = 0; k < 20000 && pick(sel) !== 1'b1; k++) @(negedge core_clk);
		bail(k);
	endtask

	task automatic take(output logic [7:0] d, output logic p, output int t);
		int k;
		for (k = 0; k < 20000 && peer.gotD.size() == 0; k++) begin
			@(negedge core_clk);
		end
		bail(k);
		d = peer.gotD.pop_front();
		p = peer.gotP.pop_front();
		t = peer.gotT.pop_front();
	endtask

	task automatic write_tx(input logic [7:0] d);
		@(negedge core_clk);
		txData = d;
		txWrite = 1'b1;
		@(negedge core_clk);
		txWrite = 1'b0;
	endtask

	// 0 pops receive data, 1 reads the identification, 2 reads line status
	task automatic strobe(input int sel);
		@(negedge core_clk);
		rxRead = (sel == 0);
		iirRead = (sel == 1);
		lineStatRead = (sel == 2);
		@(negedge core_clk);
		rxRead = 1'b0;
		iirRead = 1'b0;
		lineStatRead = 1'b0;
	endtask

	initial begin
		logic [7:0] d, m;
		logic p;
		int t0, t1, n;
		repeat (12) @(negedge core_clk);
		`CHK("serial_tx_out", 1'b1, serial_tx_out)
		`CHK("intId", IID_NONE, intId)
		`CHK("txEmpty", 1'b1, txEmpty)
		`CHK("irq", 1'b0, irq)
		rst_n = 1'b1;
		$display("test reset done");
		foreach (rows[i]) begin
			@(negedge core_clk);
			wordLen = rows[i].wl;
			parityEn = rows[i].pe;
			parityEven = rows[i].ev;
			m = 8'h_FF >> (2'h_3 - rows[i].wl);
			write_tx(rows[i].d);
			`CHK("txFull char", 1'b1, txFull)
			take(d, p, t0);
			`CHK("line data", rows[i].d & m, d)
			`CHK("parity", rows[i].pe & (^(rows[i].d & m) ^ !rows[i].ev), p)
			peer.send(rows[i].d, rows[i].ev, 1'b0, 1'b0);
			wait_hi(0);
			`CHK("rxData", rows[i].d & m, rxData)
			`CHK("parityErr", 1'b0, parityErr)
			strobe(0);
		end
		$display("test formats done");
		fifoMode = 1'b1;
		wordLen = 2'h_3;
		parityEn = 1'b0;
		for (int s = 0; s < 3; s++) begin
			stopSel = 2'(s);
			divisor = 16'(s + 1);
			write_tx(8'h_C3);
			`CHK("txFull fifo", 1'b0, txFull)
			write_tx(8'h_3C);
			write_tx(8'h_99);
			take(d, p, t0);
			take(d, p, t0);
			`CHK("second char", 8'h_3C, d)
			take(d, p, t1);
			`CHK("char gap", (144 + stopLen[s]) * (s + 1), t1 - t0)
		end
		for (n = 0; n < 200 && baudOut !== 1'b0; n++) @(negedge core_clk);
		if (n >= 200) bail(20000);
		for (n = 0; n < 200 && baudOut !== 1'b1; n++) @(negedge core_clk);
		if (n >= 200) bail(20000);
		for (n = 0; n < 200 && baudOut === 1'b1; n++) @(negedge core_clk);
		`CHK("baudOut high", 8 * 3, n)
		divisor = DIV_RESET;
		$display("test stop and baud done");
		peer.send(8'h_11, 1'b0, 1'b0, 1'b0);
		peer.send(8'h_22, 1'b0, 1'b0, 1'b0);
		wait_hi(0);
		`CHK("fifo head", 8'h_11, rxData)
		strobe(0);
		`CHK("fifo next", 8'h_22, rxData)
		strobe(0);
		`CHK("rxReady", 1'b0, rxReady)
		fifoMode = 1'b0;
		peer.send(8'h_11, 1'b0, 1'b0, 1'b0);
		peer.send(8'h_22, 1'b0, 1'b0, 1'b0);
		`CHK("overrunErr", 1'b1, overrunErr)
		`CHK("char hold", 8'h_11, rxData)
		strobe(0);
		strobe(2);
		`CHK("overrun clear", 1'b0, overrunErr)
		$display("test buffering done");
		ieLineStat = 1'b1;
		ieRxData = 1'b1;
		parityEn = 1'b1;
		parityEven = 1'b1;
		peer.send(8'h_5C, 1'b1, 1'b1, 1'b0);
		wait_hi(1);
		`CHK("parityErr", 1'b1, parityErr)
		`CHK("intId line", IID_LINE, intId)
		`CHK("bad not stored", 1'b0, rxReady)
		strobe(2);
		@(negedge core_clk);
		`CHK("irq cleared", 1'b0, irq)
		peer.send(8'h_5C, 1'b1, 1'b0, 1'b1);
		wait_hi(1);
		`CHK("frameErr", 1'b1, frameErr)
		strobe(2);
		peer.send(8'h_5C, 1'b1, 1'b0, 1'b0);
		wait_hi(1);
		`CHK("intId data", IID_RXDATA, intId)
		`CHK("rxData", 8'h_5C, rxData)
		strobe(0);
		@(negedge core_clk);
		`CHK("irq after read", 1'b0, irq)
		ieThre = 1'b1;
		write_tx(8'h_81);
		take(d, p, t0);
		wait_hi(2);
		wait_hi(1);
		`CHK("intId empty", IID_THRE, intId)
		strobe(1);
		@(negedge core_clk);
		`CHK("intId none", IID_NONE, intId)
		$display("test interrupts done");
		ieThre = 1'b0;
		ieRxData = 1'b0;
		ieLineStat = 1'b0;
		irEnable = 1'b1;
		parityEn = 1'b0;
		write_tx(8'h_00);
		n = 0;
		repeat (250) begin
			@(negedge core_clk);
			n += irTxOut;
		end
		`CHK("ir pulse cycles", 9 * 3, n)
		take(d, p, t0);
		`CHK("ir line data", 8'h_00, d)
		peer.send(8'h_96, 1'b0, 1'b0, 1'b0);
		wait_hi(0);
		`CHK("ir rxData", 8'h_96, rxData)
		$display("test infrared done");
		complete_run();
	end
endmodule
`default_nettype wire
